/* File: rtl/per_router.sv */
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - Twelve channels, each may pick any event source.
// - Each channel runs asynchronous, resynchronized or synchronous path.
// - Every consumer chooses its own channel; sharing is allowed.
// - Events pass through hardware only, no bus traffic needed.
// - Standby bit clear: idle runs only when pending, standby disabled; the async path is not gated and still passes in standby.
// - Standby bit set: channel keeps running in idle and standby.
// - On-request resynchronized_path path adds two channel clock periods of delay.
// - Works in sleep, waking only needed logic, raising interrupts.
// - Detected flag sets one cycle after propagation, never on async path.
// - Overrun flag never sets on the async path.
// - Write one clears detected flag, zero ignored; enabled flag interrupts.
module per_router #(
    parameter int NUM_USR = 8
) (
    // Clock and reset
    input  wire logic                           clock_i,
    input  wire logic                           rst_i,
    // Register port
    input  wire logic [7:0]                     addr_i,
    input  wire logic [31:0]                    wdata_i,
    input  wire logic                           wr_i,
    input  wire logic                           rd_i,
    output logic [31:0]                         rdata_o,
    // Sleep state
    input  wire logic                           idle_sleep_i,
    input  wire logic                           standby_sleep_i,
    // Event sources, from outside the clock domain
    input  wire logic [per_pkg::NUM_SRC-1:0]    src_evt_i,
    // Consumers
    input  wire logic [NUM_USR-1:0]             consumer_ready_i,
    output logic [NUM_USR-1:0]                  user_evt_o,
    output logic [NUM_USR-1:0]                  user_async_o,
    // Interrupt request and wake
    output logic                                irq_o,
    output logic                                wake_o
);
    localparam int NC = per_pkg::NUM_CH;

    // Source synchronisers
    logic [per_pkg::NUM_SRC-1:0] src_s1_r;
    logic [per_pkg::NUM_SRC-1:0] src_s2_r;
    logic [per_pkg::NUM_SRC-1:0] src_s3_r;
    logic [per_pkg::NUM_SRC-1:0] src_edge;
    logic                        stby_s1_r;
    logic                        stby_s2_r;
    logic                        idle_s1_r;
    logic                        idle_s2_r;
    logic [NUM_USR-1:0]          rdy_s1_r;
    logic [NUM_USR-1:0]          rdy_s2_r;

    // Registers
    logic [per_pkg::SRC_W-1:0]   ch_src_r  [NC];
    logic [1:0]                  ch_path_r [NC];
    logic [NC-1:0]               ch_onreq_r;
    logic [NC-1:0]               ch_stby_r;
    logic [per_pkg::CH_W:0]      usr_sel_r [NUM_USR];
    logic [31:0]                 inten_r;
    logic [NC-1:0]               evd_r;
    logic [NC-1:0]               ovr_r;
    logic [NC-1:0]               sw_evt_r;
    logic [31:0]                 rdata_nxt;

    // Channel results
    logic [NC-1:0] ch_evt;
    logic [NC-1:0] ch_async;
    logic [NC-1:0] ch_det;
    logic [NC-1:0] ch_ovr;
    logic [NC-1:0] ch_busy;
    logic [NC-1:0] ch_rdy;
    logic [NUM_USR-1:0] user_evt_nxt;
    logic [NUM_USR-1:0] user_async_nxt;

    // Decode
    logic          soft_rst;
    logic          wr_clr;
    logic          wr_set;
    logic          wr_flag;
    logic          wr_sw;
    logic          wr_ch;
    logic          wr_usr;
    logic [5:0]    ch_idx;
    logic [5:0]    usr_idx;
    logic [NC-1:0] evd_clr;
    logic [NC-1:0] ovr_clr;
    logic [31:0]   flags;

    assign soft_rst = wr_i & (addr_i == per_pkg::ADDR_CTRL) & wdata_i[per_pkg::SOFTWARE_RESET_BIT_BIT];
    assign wr_clr   = wr_i & (addr_i == per_pkg::ADDR_INTEN_CLR);
    assign wr_set   = wr_i & (addr_i == per_pkg::ADDR_INTEN_SET);
    assign wr_flag  = wr_i & (addr_i == per_pkg::ADDR_FLAGS);
    assign wr_sw    = wr_i & (addr_i == per_pkg::ADDR_SW_EVT);
    assign ch_idx   = 6'((addr_i - per_pkg::ADDR_CH_BASE) >> 2);
    assign usr_idx  = 6'((addr_i - per_pkg::ADDR_USR_BASE) >> 2);
    assign wr_ch    = wr_i & (addr_i >= per_pkg::ADDR_CH_BASE) & (ch_idx < 6'(NC))
                    & (addr_i[1:0] == 2'h0);
    assign wr_usr   = wr_i & (addr_i >= per_pkg::ADDR_USR_BASE) & (usr_idx < 6'(NUM_USR))
                    & (addr_i[1:0] == 2'h0);
    assign evd_clr  = wr_flag ? wdata_i[per_pkg::EVD_LSB +: NC] : '0;
    assign ovr_clr  = wr_flag ? wdata_i[per_pkg::OVR_LSB +: NC] : '0;
    assign flags    = {4'h0, evd_r, 4'h0, ovr_r};

    // Two-flop synchronisers for pins and sleep signals
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            src_s1_r  <= '0;
            src_s2_r  <= '0;
            src_s3_r  <= '0;
            stby_s1_r <= 1'b0;
            stby_s2_r <= 1'b0;
            idle_s1_r <= 1'b0;
            idle_s2_r <= 1'b0;
            rdy_s1_r  <= '0;
            rdy_s2_r  <= '0;
        end else begin
            src_s1_r  <= src_evt_i;
            src_s2_r  <= src_s1_r;
            src_s3_r  <= src_s2_r;
            stby_s1_r <= standby_sleep_i;
            stby_s2_r <= stby_s1_r;
            idle_s1_r <= idle_sleep_i;
            idle_s2_r <= idle_s1_r;
            rdy_s1_r  <= consumer_ready_i;
            rdy_s2_r  <= rdy_s1_r;
        end
    end

    // Rising edge of synchronised sources forms a one-cycle event
    assign src_edge = src_s2_r & ~src_s3_r;

    // Channels, each fully independent
    for (genvar c = 0; c < NC; c++) begin : g_ch
        // A channel is ready when every consumer listening to it is ready
        always_comb begin
            ch_rdy[c] = 1'b1;
            for (int u = 0; u < NUM_USR; u++) begin
                if (usr_sel_r[u] == (per_pkg::CH_W+1)'(c + 1) && !rdy_s2_r[u]) begin
                    ch_rdy[c] = 1'b0;
                end
            end
        end

        per_channel u_ch (
            .clock_i                   (clock_i),
            .rst_i                     (rst_i),
            .src_sel_i                 (ch_src_r[c]),
            .path_i                    (ch_path_r[c]),
            .run_on_request_i          (ch_onreq_r[c]),
            .keep_running_in_standby_i (ch_stby_r[c]),
            .idle_sleep_i              (idle_s2_r),
            .standby_sleep_i           (stby_s2_r),
            .src_sync_i                (src_edge),
            .src_raw_i                 (src_evt_i),
            .sw_evt_i                  (sw_evt_r[c]),
            .consumer_ready_i          (ch_rdy[c]),
            .evt_o                     (ch_evt[c]),
            .async_o                   (ch_async[c]),
            .detect_o                  (ch_det[c]),
            .overrun_o                 (ch_ovr[c]),
            .busy_o                    (ch_busy[c])
        );
    end

    // Consumer routing, each picks its own channel
    always_comb begin
        user_evt_nxt   = '0;
        user_async_nxt = '0;
        for (int u = 0; u < NUM_USR; u++) begin
            for (int c = 0; c < NC; c++) begin
                if (usr_sel_r[u] == (per_pkg::CH_W+1)'(c + 1)) begin
                    user_evt_nxt[u]   = ch_evt[c];
                    user_async_nxt[u] = ch_async[c];
                end
            end
        end
    end

    // Channel and consumer configuration
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            for (int c = 0; c < NC; c++) begin
                ch_src_r[c]  <= '0;
                ch_path_r[c] <= per_pkg::PER_PATH_SYNC;
            end
            ch_onreq_r <= '0;
            ch_stby_r  <= '0;
            for (int u = 0; u < NUM_USR; u++) usr_sel_r[u] <= per_pkg::USR_NONE;
        end else if (soft_rst) begin
            for (int c = 0; c < NC; c++) begin
                ch_src_r[c]  <= '0;
                ch_path_r[c] <= per_pkg::PER_PATH_SYNC;
            end
            ch_onreq_r <= '0;
            ch_stby_r  <= '0;
            for (int u = 0; u < NUM_USR; u++) usr_sel_r[u] <= per_pkg::USR_NONE;
        end else begin
            if (wr_ch) begin
                ch_src_r[ch_idx[3:0]]   <= wdata_i[per_pkg::CFG_SRC_LSB +: per_pkg::SRC_W];
                ch_path_r[ch_idx[3:0]]  <= wdata_i[per_pkg::CFG_PATH_LSB +: 2];
                ch_onreq_r[ch_idx[3:0]] <= wdata_i[per_pkg::CFG_ONREQ_BIT];
                ch_stby_r[ch_idx[3:0]]  <= wdata_i[per_pkg::CFG_RUNSTBY_BIT];
            end
            if (wr_usr) begin
                usr_sel_r[usr_idx[$clog2(NUM_USR)-1:0]] <= wdata_i[per_pkg::CH_W:0];
            end
        end
    end

    // Enables, flags and software events; hardware set wins over clear
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            inten_r  <= '0;
            evd_r    <= '0;
            ovr_r    <= '0;
            sw_evt_r <= '0;
        end else if (soft_rst) begin
            inten_r  <= '0;
            evd_r    <= '0;
            ovr_r    <= '0;
            sw_evt_r <= '0;
        end else begin
            inten_r  <= (inten_r & ~(wr_clr ? wdata_i : 32'h0))
                      | (wr_set ? wdata_i : 32'h0);
            evd_r    <= (evd_r & ~evd_clr) | ch_det;
            ovr_r    <= (ovr_r & ~ovr_clr) | ch_ovr;
            sw_evt_r <= wr_sw ? wdata_i[NC-1:0] : '0;
        end
    end

    // Read mux; unmapped addresses and the trigger register read zero
    always_comb begin
        rdata_nxt = 32'h0;
        if (rd_i) begin
            unique case (addr_i)
                per_pkg::ADDR_STATUS:    rdata_nxt = {4'h0, ch_busy, 4'h0, ch_rdy};
                per_pkg::ADDR_INTEN_CLR: rdata_nxt = inten_r & 32'h0fff0fff;
                per_pkg::ADDR_INTEN_SET: rdata_nxt = inten_r & 32'h0fff0fff;
                per_pkg::ADDR_FLAGS:     rdata_nxt = flags;
                default: begin
                    if (wr_ch | (rd_i & (addr_i >= per_pkg::ADDR_CH_BASE) & (ch_idx < 6'(NC))
                        & (addr_i[1:0] == 2'h0))) begin
                        rdata_nxt = {16'h0, ch_onreq_r[ch_idx[3:0]], ch_stby_r[ch_idx[3:0]],
                                     4'h0, ch_path_r[ch_idx[3:0]], 4'h0, ch_src_r[ch_idx[3:0]]};
                    end else if ((addr_i >= per_pkg::ADDR_USR_BASE) & (usr_idx < 6'(NUM_USR))
                        & (addr_i[1:0] == 2'h0)) begin
                        rdata_nxt = {27'h0, usr_sel_r[usr_idx[$clog2(NUM_USR)-1:0]]};
                    end
                end
            endcase
        end
    end

    // Registered outputs
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o      <= 32'h0;
            irq_o        <= 1'b0;
            wake_o       <= 1'b0;
            user_evt_o   <= '0;
            user_async_o <= '0;
        end else begin
            rdata_o      <= rdata_nxt;
            irq_o        <= |(flags & inten_r);
            wake_o       <= |ch_busy;
            user_evt_o   <= user_evt_nxt;
            user_async_o <= user_async_nxt;
        end
    end
endmodule // per_router

/* File: rtl/per_pkg.sv */
package per_pkg;
    // Channel and source counts
    localparam int NUM_CH  = 12;
    localparam int NUM_SRC = 16;
    localparam int SRC_W   = 4;
    localparam int CH_W    = 4;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h0c;
    localparam logic [7:0] ADDR_INTEN_CLR = 8'h10;
    localparam logic [7:0] ADDR_INTEN_SET = 8'h14;
    localparam logic [7:0] ADDR_FLAGS     = 8'h18;
    localparam logic [7:0] ADDR_SW_EVT    = 8'h1c;
    // Channel configuration registers: base + 4 * channel
    localparam logic [7:0] ADDR_CH_BASE   = 8'h20;
    // Consumer selection registers: base + 4 * consumer
    localparam logic [7:0] ADDR_USR_BASE  = 8'h60;
    // Field positions
    localparam int SOFTWARE_RESET_BIT_BIT   = 0;
    localparam int OVR_LSB     = 0;
    localparam int EVD_LSB     = 16;
    localparam int BUSY_LSB    = 16;
    localparam int CFG_SRC_LSB = 0;
    localparam int CFG_PATH_LSB = 8;
    localparam int CFG_RUNSTBY_BIT = 14;
    localparam int CFG_ONREQ_BIT = 15;
    // Consumer selection: 0 means none, n+1 means channel n
    localparam logic [CH_W:0] USR_NONE = 5'h00;
    // Resynchronized_path delay on request, in channel clock periods
    localparam int ONREQ_DELAY = 2;
    // Path encodings
    typedef enum logic [1:0] {
        PER_PATH_SYNC   = 2'h0,
        PER_PATH_RESYNCHRONIZED_PATH = 2'h1,
        PER_PATH_ASYNC  = 2'h2
    } per_path_t;
endpackage

/* File: rtl/per_channel.sv */
`timescale 1ns/1ps
// One event channel: source select, path handling, sleep gating, flags
module per_channel (
    // Clock and reset
    input  wire logic                         clock_i,
    input  wire logic                         rst_i,
    // Configuration
    input  wire logic [per_pkg::SRC_W-1:0]    src_sel_i,
    input  wire logic [1:0]                   path_i,
    input  wire logic                         run_on_request_i,
    input  wire logic                         keep_running_in_standby_i,
    input  wire logic                         idle_sleep_i,
    input  wire logic                         standby_sleep_i,
    // Events
    input  wire logic [per_pkg::NUM_SRC-1:0]  src_sync_i,
    input  wire logic [per_pkg::NUM_SRC-1:0]  src_raw_i,
    input  wire logic                         sw_evt_i,
    input  wire logic                         consumer_ready_i,
    // Results
    output logic                              evt_o,
    output logic                              async_o,
    output logic                              detect_o,
    output logic                              overrun_o,
    output logic                              busy_o
);
    logic       raw_sel;
    logic       sync_sel;
    logic       enabled;
    logic       pend_r;
    logic [1:0] dly_r;
    logic       resynchronized_path_evt;
    logic       fire;
    logic       is_async;

    assign raw_sel  = src_raw_i[src_sel_i];
    assign sync_sel = src_sync_i[src_sel_i] | sw_evt_i;
    assign is_async = (path_i == per_pkg::PER_PATH_ASYNC);
    // Disabled in standby unless kept running, except the async path; idle runs only with work pending
    assign enabled  = ~standby_sleep_i | keep_running_in_standby_i;
    // Resynchronized_path path gets two extra periods when running on request
    assign resynchronized_path_evt = run_on_request_i ? dly_r[1] : sync_sel;
    assign fire     = enabled & ((path_i == per_pkg::PER_PATH_RESYNCHRONIZED_PATH) ? resynchronized_path_evt : sync_sel);
    // Async path is combinational through the channel; the router registers user_async_o on the clock
    assign async_o  = is_async & raw_sel;

    // Delay line and pending state
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            dly_r  <= 2'h0;
            pend_r <= 1'b0;
        end else begin
            dly_r  <= {dly_r[0], sync_sel & run_on_request_i};
            pend_r <= (pend_r & ~consumer_ready_i) | (fire & ~is_async);
        end
    end

    // Outputs, flags never fire on the async path
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            evt_o     <= 1'b0;
            detect_o  <= 1'b0;
            overrun_o <= 1'b0;
            busy_o    <= 1'b0;
        end else begin
            evt_o     <= fire & ~is_async;
            detect_o  <= fire & ~is_async;
            overrun_o <= fire & ~is_async & pend_r & ~consumer_ready_i;
            busy_o    <= pend_r | (idle_sleep_i & fire);
        end
    end
endmodule // per_channel

/* File: bench/per_chk.sv */
`timescale 1ns/1ps
// Judges register reads and the interrupt line from the top ports alone
module per_chk #(
    parameter int NUM_USR = 8
) (
    // Clock and reset
    input wire logic        clock_i,
    input wire logic        rst_i,
    // Register port
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    // Interrupt
    input wire logic        irq_o
);
    logic [31:0] en_r;
    // Shadow enables; zeros written through either view must not move a bit
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            en_r <= 32'h0;
        end else if (wr_i && addr_i == per_pkg::ADDR_CTRL && wdata_i[0]) begin
            en_r <= 32'h0;
        end else if (wr_i && addr_i == per_pkg::ADDR_INTEN_SET) begin
            en_r <= en_r | (wdata_i & 32'h0fff0fff);
        end else if (wr_i && addr_i == per_pkg::ADDR_INTEN_CLR) begin
            en_r <= en_r & ~wdata_i;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Read side
    a_read_quiet: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data not zero outside a read");
    a_software_event_trigger_zero: assert property (rd_i && addr_i == per_pkg::ADDR_SW_EVT |=> rdata_o == 32'h0)
        else $error("software event register did not read zero");
    a_enset_view: assert property (rd_i && addr_i == per_pkg::ADDR_INTEN_SET |=> rdata_o == $past(en_r))
        else $error("set view of enables wrong");
    a_enclr_view: assert property (rd_i && addr_i == per_pkg::ADDR_INTEN_CLR |=> rdata_o == $past(en_r))
        else $error("clear view of enables wrong");
    a_flag_layout: assert property (rd_i && addr_i == per_pkg::ADDR_FLAGS |=> (rdata_o & 32'hf000f000) == 32'h0)
        else $error("flag register shows reserved bits");
    // Interrupt side
    a_irq_needs_en: assert property (irq_o |-> $past(en_r) != 32'h0)
        else $error("interrupt with every enable clear");
    a_software_event_trigger_irq: assert property (wr_i && addr_i == per_pkg::ADDR_SW_EVT && (wdata_i[11:0] & en_r[27:16]) != 12'h0 |-> ##4 irq_o)
        else $error("enabled software event raised no interrupt");
    a_flag_clear: assert property (wr_i && addr_i == per_pkg::ADDR_FLAGS && wdata_i == 32'h0fff0fff |-> ##2 !irq_o)
        else $error("interrupt stayed after all flags cleared");
    a_soft_quiet: assert property (wr_i && addr_i == per_pkg::ADDR_CTRL && wdata_i[0] |-> ##2 (!irq_o) [*3])
        else $error("interrupt after soft reset");
endmodule // per_chk

bind per_router per_chk #(.NUM_USR(NUM_USR)) i_per_chk (.clock_i(clock_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o));

/* File: bench/per_peer.sv */
`timescale 1ns/1ps
// Event generators and consumers around the router
module per_peer (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // Bench commands
    input  wire logic        kick_i,
    input  wire logic [3:0]  src_idx_i,
    input  wire logic        stall_i,
    // Towards the router
    output logic [15:0]      src_evt_o,
    output logic [7:0]       ready_o
);
    logic [2:0] hold_r;
    // A source level stands five cycles so the synchronizer cannot miss it
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            src_evt_o <= 16'h0;
            hold_r    <= 3'h0;
        end else if (kick_i) begin
            src_evt_o <= 16'h0001 << src_idx_i;
            hold_r    <= 3'h4;
        end else if (hold_r != 3'h0) begin
            hold_r <= hold_r - 3'h1;
        end else begin
            src_evt_o <= 16'h0;
        end
    end
    // Consumers refuse only while the bench stalls them
    assign ready_o = stall_i ? 8'h00 : 8'hff;
endmodule // per_peer

/* File: bench/per_router_tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the event router
module per_router_tb;
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        idle_sleep_i = 1'b0;
    logic        standby_sleep_i = 1'b0;
    logic        kick = 1'b0;
    logic [3:0]  kick_src = 4'h0;
    logic        stall = 1'b0;
    logic [31:0] rdata_o;
    logic [15:0] src_evt_i;
    logic [7:0]  consumer_ready_i, user_evt_o, user_async_o;
    logic        irq_o, wake_o;
    int          err_total = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          k, k0;
    logic [31:0] rv;
    // Design and its surroundings
    per_router #(.NUM_USR(8)) i_per_router (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .idle_sleep_i(idle_sleep_i), .standby_sleep_i(standby_sleep_i), .src_evt_i(src_evt_i),
        .consumer_ready_i(consumer_ready_i), .user_evt_o(user_evt_o),
        .user_async_o(user_async_o), .irq_o(irq_o), .wake_o(wake_o));
    per_peer i_per_peer (.clock_i(clock_i), .rst_i(rst_i), .kick_i(kick), .src_idx_i(kick_src),
        .stall_i(stall), .src_evt_o(src_evt_i), .ready_o(consumer_ready_i));
    // Clock and hang guard
    always #2.5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bus cycles: one strobe cycle each, read data taken in the cycle after
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        #1;
        rv = rdata_o;
        chk($sformatf("register %h", a), exp, rv);
    endtask
    task automatic cfg(input int c, input logic [3:0] s, input logic [1:0] p, input logic kp,
                       input logic oq);
        wr(per_pkg::ADDR_CH_BASE + 8'(4 * c), {16'h0, oq, kp, 4'h0, p, 4'h0, s});
    endtask
    task automatic usr(input int u, input int c);
        wr(per_pkg::ADDR_USR_BASE + 8'(4 * u), 32'(c + 1));
    endtask
    task automatic fire(input logic [3:0] s);
        @(posedge clock_i);
        kick     <= 1'b1;
        kick_src <= s;
        @(posedge clock_i);
        kick <= 1'b0;
    endtask
    // Edges from the launching edge until consumer u pulses; 16 means never
    task automatic lat(input int u, output int n);
        n = 0;
        do begin
            @(posedge clock_i);
            #1;
            n++;
        end while (user_evt_o[u] !== 1'b1 && n < 16);
    endtask
    task automatic t_regs();
        rdc(per_pkg::ADDR_FLAGS, 32'h0);
        rdc(8'h04, 32'h0);
        wr(per_pkg::ADDR_INTEN_SET, 32'h0fff0fff);
        wr(per_pkg::ADDR_INTEN_CLR, 32'h00000001);
        wr(per_pkg::ADDR_INTEN_SET, 32'h0);
        rdc(per_pkg::ADDR_INTEN_CLR, 32'h0fff0ffe);
        wr(per_pkg::ADDR_CTRL, 32'h1);
        rdc(per_pkg::ADDR_INTEN_SET, 32'h0);
    endtask
    task automatic t_route();
        for (int c = 0; c < per_pkg::NUM_CH; c++) begin
            cfg(c, 4'(15 - c), 2'h0, 1'b0, 1'b0);
            usr(0, c);
            fire(4'(15 - c));
            lat(0, k);
            chk($sformatf("latency of channel %0d", c), 32'h4, 32'(k));
        end
    endtask
    task automatic t_paths();
        wr(per_pkg::ADDR_FLAGS, 32'h0fff0fff);
        usr(3, 3);
        // Source 2 feeds no other channel, so only channel 3 can raise a flag here
        cfg(3, 4'h2, per_pkg::PER_PATH_SYNC, 1'b0, 1'b0);
        fire(4'h2);
        lat(3, k0);
        cfg(3, 4'h2, per_pkg::PER_PATH_RESYNCHRONIZED_PATH, 1'b0, 1'b1);
        fire(4'h2);
        lat(3, k);
        chk("on request delay", 32'h2, 32'(k - k0));
        rdc(per_pkg::ADDR_FLAGS, 32'h00080000);
        wr(per_pkg::ADDR_FLAGS, 32'h0fff0fff);
        cfg(3, 4'h2, per_pkg::PER_PATH_ASYNC, 1'b0, 1'b0);
        fire(4'h2);
        rv = 32'h0;
        repeat (8) begin
            @(posedge clock_i);
            #1;
            rv[0] = rv[0] | user_async_o[3];
        end
        chk("async copy", 32'h1, rv);
        rdc(per_pkg::ADDR_FLAGS, 32'h0);
    endtask
    task automatic t_sw();
        usr(0, 11);
        usr(1, 11);
        usr(2, 0);
        wr(per_pkg::ADDR_INTEN_SET, 32'h08000000);
        wr(per_pkg::ADDR_SW_EVT, 32'h00000800);
        lat(0, k);
        chk("software latency", 32'h2, 32'(k));
        chk("shared channel", 32'h3, {24'h0, user_evt_o});
        @(posedge clock_i);
        #1;
        chk("interrupt", 32'h1, {31'h0, irq_o});
        wr(per_pkg::ADDR_SW_EVT, 32'h00000fff);
        rdc(per_pkg::ADDR_SW_EVT, 32'h0);
        rdc(per_pkg::ADDR_FLAGS, 32'h0ff70000);
        wr(per_pkg::ADDR_FLAGS, 32'h0);
        rdc(per_pkg::ADDR_FLAGS, 32'h0ff70000);
        wr(per_pkg::ADDR_FLAGS, 32'h0fff0fff);
        rdc(per_pkg::ADDR_FLAGS, 32'h0);
        chk("interrupt gone", 32'h0, {31'h0, irq_o});
        usr(2, 2);
        @(posedge clock_i);
        stall <= 1'b1;
        wr(per_pkg::ADDR_SW_EVT, 32'h00000004);
        wr(per_pkg::ADDR_SW_EVT, 32'h00000004);
        // Overrun comes from the second event and reaches the flag register two edges after the first detect flag
        @(posedge clock_i);
        rdc(per_pkg::ADDR_FLAGS, 32'h00040004);
        chk("wake", 32'h1, {31'h0, wake_o});
        rdc(per_pkg::ADDR_STATUS, 32'h000407f3);
        @(posedge clock_i);
        stall <= 1'b0;
    endtask
    task automatic t_sleep();
        usr(0, 6);
        cfg(6, 4'h9, 2'h0, 1'b0, 1'b0);
        @(posedge clock_i);
        standby_sleep_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        fire(4'h9);
        lat(0, k);
        chk("standby drops", 32'h10, 32'(k));
        cfg(6, 4'h9, 2'h0, 1'b1, 1'b0);
        fire(4'h9);
        lat(0, k);
        chk("standby keeps", 32'h1, 32'(k < 16));
        @(posedge clock_i);
        standby_sleep_i <= 1'b0;
        idle_sleep_i    <= 1'b1;
        cfg(6, 4'h9, 2'h0, 1'b0, 1'b0);
        repeat (4) @(posedge clock_i);
        fire(4'h9);
        lat(0, k);
        chk("idle passes", 32'h1, 32'(k < 16));
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clock_i);
        rst_i <= 1'b0;
        t_regs();
        t_route();
        t_paths();
        t_sw();
        t_sleep();
        close_out();
    end
endmodule // per_router_tb
